// >>> inc/rcr_pkg.sv
// Constants, field layout and bus carrier types for the regulator control bank.
// Assumes a single AXI4-Lite slave port with 32-bit data and byte addresses.
package rcr_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam int          RCR_ADDR_W       = 32;
    localparam int          RCR_DATA_W       = 32;
    localparam logic [31:0] RCR_BASE_ADDR    = 32'h4003_9000;
    localparam logic [31:0] RCR_SET_OFFSET   = 32'h0000_0004;
    localparam logic [31:0] RCR_CLR_OFFSET   = 32'h0000_0008;
    localparam logic [31:0] RCR_MASK_OFFSET  = 32'h0000_000C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RCR_CODE_W        = 5;
    localparam int RCR_DIG_SRC_BIT   = 22;
    localparam int RCR_DIG_BIAS_BIT  = 21;
    localparam int RCR_DIG_CODE_LSB  = 16;
    localparam int RCR_MEM_SRC_BIT   = 14;
    localparam int RCR_MEM_BIAS_BIT  = 13;
    localparam int RCR_MEM_CODE_LSB  = 8;
    localparam int RCR_ANA_SRC_BIT   = 6;
    localparam int RCR_ANA_BIAS_BIT  = 5;
    localparam int RCR_ANA_CODE_LSB  = 0;

    // Writable bits; bits 31:23, 15 and 7 are reserved and read as zero.
    localparam logic [31:0] RCR_WRITE_MASK   = 32'h007F_7F7F;
    // Source battery, high bias, code 0x14 (1.8 V) for all three.
    localparam logic [31:0] RCR_RESET_VALUE  = 32'h0034_3434;

    // Nominal output voltage in mV: base plus step times code.
    localparam int RCR_VOUT_BASE_MV  = 800;
    localparam int RCR_VOUT_STEP_MV  = 50;

    // ****************************************************************
    // Alias kinds and responses
    // ****************************************************************
    typedef enum logic [2:0]
    {
        RCR_ALIAS_PLAIN = 3'b001,
        RCR_ALIAS_SET   = 3'b010,
        RCR_ALIAS_CLR   = 3'b100
    } rcr_alias_t;

    localparam logic [1:0] RCR_RESP_OKAY   = 2'b00;
    localparam logic [1:0] RCR_RESP_SLVERR = 2'b10;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed
    {
        logic                   source_sel;
        logic                   bias_sel;
        logic [RCR_CODE_W-1:0]  out_code;
    } rcr_reg_ctl_t;

    typedef struct packed
    {
        logic       hit;
        rcr_alias_t alias_kind;
    } rcr_decode_t;

    typedef struct packed
    {
        logic [RCR_ADDR_W-1:0]   addr;
        logic [RCR_DATA_W-1:0]   data;
        logic [RCR_DATA_W/8-1:0] strb;
    } rcr_wreq_t;

endpackage

// >>> rtl/rcr_addr_decode.sv
// Address decoder for the plain, set and clear aliases of the control word.
// Assumes byte addresses; the mask alias twelve bytes up is not decoded.
`timescale 1ns/1ps

module rcr_addr_decode
#(
    parameter logic [31:0] BASE_ADDR = rcr_pkg::RCR_BASE_ADDR
)
(
    // Address to classify
    input  wire logic [rcr_pkg::RCR_ADDR_W-1:0] addr,
    // Classification
    output rcr_pkg::rcr_decode_t                decode
);

    // ****************************************************************
    // Alias match
    // ****************************************************************

    // Any other address, the mask alias included, is a miss.
    always_comb
    begin
        decode.hit        = 1'b0;
        decode.alias_kind = rcr_pkg::RCR_ALIAS_PLAIN;
        if (addr == BASE_ADDR)
        begin
            decode.hit = 1'b1;
        end
        // R1: set alias
        else if (addr == BASE_ADDR + rcr_pkg::RCR_SET_OFFSET)
        begin
            decode.hit        = 1'b1;
            decode.alias_kind = rcr_pkg::RCR_ALIAS_SET;
        end
        // R2: clear alias
        else if (addr == BASE_ADDR + rcr_pkg::RCR_CLR_OFFSET)
        begin
            decode.hit        = 1'b1;
            decode.alias_kind = rcr_pkg::RCR_ALIAS_CLR;
        end
    end

endmodule

// >>> rtl/rcr_field_unpack.sv
// Splits the stored control word into the three regulators' control groups.
// Assumes the word is held in a flip-flop so the outputs are static levels.
`timescale 1ns/1ps

module rcr_field_unpack
(
    // Stored control word
    input  wire logic [rcr_pkg::RCR_DATA_W-1:0] ctl_word,
    // Per-regulator controls
    output rcr_pkg::rcr_reg_ctl_t               digital_ctl,
    output rcr_pkg::rcr_reg_ctl_t               memory_ctl,
    output rcr_pkg::rcr_reg_ctl_t               analog_ctl
);

    // ****************************************************************
    // Field extraction
    // ****************************************************************

    // R5: digital source select
    assign digital_ctl.source_sel = ctl_word[rcr_pkg::RCR_DIG_SRC_BIT];
    // R6: digital bias select
    assign digital_ctl.bias_sel   = ctl_word[rcr_pkg::RCR_DIG_BIAS_BIT];
    // R7: digital output code
    assign digital_ctl.out_code   =
        ctl_word[rcr_pkg::RCR_DIG_CODE_LSB +: rcr_pkg::RCR_CODE_W];

    // R8: memory source select
    assign memory_ctl.source_sel  = ctl_word[rcr_pkg::RCR_MEM_SRC_BIT];
    // R9: memory bias select
    assign memory_ctl.bias_sel    = ctl_word[rcr_pkg::RCR_MEM_BIAS_BIT];
    // R10: memory output code
    assign memory_ctl.out_code    =
        ctl_word[rcr_pkg::RCR_MEM_CODE_LSB +: rcr_pkg::RCR_CODE_W];

    // R11: analog source select
    assign analog_ctl.source_sel  = ctl_word[rcr_pkg::RCR_ANA_SRC_BIT];
    // R12: analog bias select
    assign analog_ctl.bias_sel    = ctl_word[rcr_pkg::RCR_ANA_BIAS_BIT];
    // R13: analog output code
    assign analog_ctl.out_code    =
        ctl_word[rcr_pkg::RCR_ANA_CODE_LSB +: rcr_pkg::RCR_CODE_W];

endmodule

// >>> rtl/rcr_top.sv
// Regulator control register bank with an AXI4-Lite slave port.
// Assumes one clock, a synchronous active-low reset and regulators that
// take the control outputs as static levels.
//
// How it works
// R1: The control word also answers at the set alias, four bytes up.
// R2: The control word also answers at the clear alias, eight bytes up.
// R3: The mask alias twelve bytes up is not decoded; it errors.
// R4: Reserved bits 31:23, 15 and 7 read zero; software writes zero.
// R5: Bit 22 picks digital regulator input: battery or converter.
// R6: Bit 21 picks digital regulator bias: low or high.
// R7: Bits 20:16 hold digital output code, reset to 1.8 V.
// R8: Bit 14 picks memory regulator input: battery or converter.
// R9: Bit 13 picks memory regulator bias: low or high.
// R10: Bits 12:8 hold memory output code, reset to 1.8 V.
// R11: Bit 6 picks analog regulator input: battery or converter.
// R12: Bit 5 picks analog regulator bias: low or high.
// R13: Bits 4:0 hold analog output code, reset to 1.8 V.
// R14: Code maps to 0.8 V plus 50 mV per step.
// R15: Reset gives battery input, high bias and 1.8 V everywhere.
// R16: Software enables the converter before selecting it as input.
// R17: Source bits change at any time with no extra sequence.
// R18: Software keeps analog code at or above memory code.
// R19: Software raises memory code to 1.8 V before flash work.
// R20: Software sets recommended codes before the deepest sleep mode.
// R21: Set alias ORs ones in, clear alias clears ones; reads see value.
// R22: Fields drive outputs continuously, updated at the next edge.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps

module rcr_top
#(
    parameter logic [31:0] BASE_ADDR = rcr_pkg::RCR_BASE_ADDR
)
(
    // Clock and reset
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // Write address channel
    input  wire logic [rcr_pkg::RCR_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]                      s_axi_awprot,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    // Write data channel
    input  wire logic [rcr_pkg::RCR_DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    // Write response channel
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    // Read address channel
    input  wire logic [rcr_pkg::RCR_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]                      s_axi_arprot,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    // Read data channel
    output logic [rcr_pkg::RCR_DATA_W-1:0]       s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    // Digital regulator controls
    output logic                                 digital_reg_source_sel,
    output logic                                 digital_reg_bias_sel,
    output logic [rcr_pkg::RCR_CODE_W-1:0]       digital_reg_out_code,
    // Memory regulator controls
    output logic                                 memory_reg_source_sel,
    output logic                                 memory_reg_bias_sel,
    output logic [rcr_pkg::RCR_CODE_W-1:0]       memory_reg_out_code,
    // Analog regulator controls
    output logic                                 analog_reg_source_sel,
    output logic                                 analog_reg_bias_sel,
    output logic [rcr_pkg::RCR_CODE_W-1:0]       analog_reg_out_code
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Expand byte strobes into a bit mask.
    function automatic logic [31:0] strb_to_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Next control word for a write through the given alias.
    function automatic logic [31:0] alias_update(
        input logic [31:0]         cur,
        input logic [31:0]         data,
        input logic [31:0]         lanes,
        input rcr_pkg::rcr_alias_t kind
    );
        logic [31:0] nxt;
        nxt = cur;
        case (kind)
            rcr_pkg::RCR_ALIAS_PLAIN: nxt = (cur & ~lanes) | (data & lanes);
            rcr_pkg::RCR_ALIAS_SET:   nxt = cur | (data & lanes);
            rcr_pkg::RCR_ALIAS_CLR:   nxt = cur & ~(data & lanes);
            default:                  nxt = cur;
        endcase
        // R4: reserved bits held at zero
        return nxt & rcr_pkg::RCR_WRITE_MASK;
    endfunction

    // ****************************************************************
    // Write channel capture
    // ****************************************************************
    logic                 aw_full_q;
    logic                 w_full_q;
    logic [31:0]          awaddr_q;
    rcr_pkg::rcr_wreq_t   wreq_q;
    logic [31:0]          ctl_q;
    logic [31:0]          ctl_d;
    logic                 write_fire;
    rcr_pkg::rcr_decode_t wr_dec;
    rcr_pkg::rcr_decode_t rd_dec;

    // Channels are accepted only while no response is pending, so one
    // write at a time is in flight and address and data may come apart.
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign write_fire    = aw_full_q && w_full_q && !s_axi_bvalid;

    // Write address holding register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (write_fire)
        begin
            aw_full_q <= 1'b0;
        end
    end

    // Write data holding register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q    <= 1'b0;
            wreq_q.addr <= 32'h0000_0000;
            wreq_q.data <= 32'h0000_0000;
            wreq_q.strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_full_q    <= 1'b1;
            wreq_q.addr <= 32'h0000_0000;
            wreq_q.data <= s_axi_wdata;
            wreq_q.strb <= s_axi_wstrb;
        end
        else if (write_fire)
        begin
            w_full_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Decode
    // ****************************************************************

    // R3: mask alias left undecoded
    rcr_addr_decode #(
        .BASE_ADDR (BASE_ADDR)
    ) u_wr_decode (
        .addr   (awaddr_q),
        .decode (wr_dec)
    );

    rcr_addr_decode #(
        .BASE_ADDR (BASE_ADDR)
    ) u_rd_decode (
        .addr   (s_axi_araddr),
        .decode (rd_dec)
    );

    // ****************************************************************
    // Control word
    // ****************************************************************

    // R21: alias write effects
    always_comb
    begin
        ctl_d = ctl_q;
        if (write_fire && wr_dec.hit)
        begin
            ctl_d = alias_update(ctl_q, wreq_q.data, strb_to_mask(wreq_q.strb),
                                 wr_dec.alias_kind);
        end
    end

    // R15: reset to battery, high bias, 1.8 V
    // R17: source bits take effect without sequencing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_q <= rcr_pkg::RCR_RESET_VALUE;
        end
        else
        begin
            ctl_q <= ctl_d;
        end
    end

    // ****************************************************************
    // Write response
    // ****************************************************************

    // Unmapped addresses, the mask alias among them, answer SLVERR.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rcr_pkg::RCR_RESP_OKAY;
        end
        else if (write_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_dec.hit ? rcr_pkg::RCR_RESP_OKAY
                                       : rcr_pkg::RCR_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    // A new read is taken only once the previous data has been consumed.
    assign s_axi_arready = !s_axi_rvalid;

    // R21: plain, set and clear aliases read back the word
    // R4: reserved bits read as zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= rcr_pkg::RCR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_dec.hit ? (ctl_q & rcr_pkg::RCR_WRITE_MASK)
                                       : 32'h0000_0000;
            s_axi_rresp  <= rd_dec.hit ? rcr_pkg::RCR_RESP_OKAY
                                       : rcr_pkg::RCR_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Regulator outputs
    // ****************************************************************
    rcr_pkg::rcr_reg_ctl_t dig_ctl;
    rcr_pkg::rcr_reg_ctl_t mem_ctl;
    rcr_pkg::rcr_reg_ctl_t ana_ctl;

    // R14: codes pass unchanged; the regulator maps code to voltage
    rcr_field_unpack u_unpack (
        .ctl_word    (ctl_q),
        .digital_ctl (dig_ctl),
        .memory_ctl  (mem_ctl),
        .analog_ctl  (ana_ctl)
    );

    // R22: outputs follow the stored word directly
    assign digital_reg_source_sel = dig_ctl.source_sel;
    assign digital_reg_bias_sel   = dig_ctl.bias_sel;
    assign digital_reg_out_code   = dig_ctl.out_code;
    assign memory_reg_source_sel  = mem_ctl.source_sel;
    assign memory_reg_bias_sel    = mem_ctl.bias_sel;
    assign memory_reg_out_code    = mem_ctl.out_code;
    assign analog_reg_source_sel  = ana_ctl.source_sel;
    assign analog_reg_bias_sel    = ana_ctl.bias_sel;
    assign analog_reg_out_code    = ana_ctl.out_code;

endmodule

// >>> dv/rcr_checker.sv
// Assertions on the bus port and regulator outputs of the control bank.
// Assumes it is bound to rcr_top and sees only that module's ports.
`timescale 1ns/1ps

module rcr_checker
#(
    parameter logic [31:0] BASE_ADDR = 32'h4003_9000
)
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Regulator controls
    input wire logic        digital_reg_source_sel,
    input wire logic        digital_reg_bias_sel,
    input wire logic [4:0]  digital_reg_out_code,
    input wire logic        memory_reg_source_sel,
    input wire logic        memory_reg_bias_sel,
    input wire logic [4:0]  memory_reg_out_code,
    input wire logic        analog_reg_source_sel,
    input wire logic        analog_reg_bias_sel,
    input wire logic [4:0]  analog_reg_out_code
);
    // The outputs regrouped into the register layout, reserved bits zero.
    wire logic [31:0] ctl = {9'h0, digital_reg_source_sel, digital_reg_bias_sel,
        digital_reg_out_code, 1'b0, memory_reg_source_sel, memory_reg_bias_sel,
        memory_reg_out_code, 1'b0, analog_reg_source_sel, analog_reg_bias_sel,
        analog_reg_out_code};
    wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire logic rd_take = s_axi_arvalid && s_axi_arready;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reset_word:
    assert property ($rose(aresetn) |-> ctl == 32'h0034_3434) else $error("Bad reset word.");
    chk_write_answer:
    assert property (wr_take |=> ##1 s_axi_bvalid) else $error("Write not answered.");
    chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped.");
    chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped.");
    chk_read_answer:
    assert property (rd_take |=> s_axi_rvalid) else $error("Read not answered.");
    chk_write_block:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken while answering.");
    chk_read_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("Read taken while busy.");
    chk_outputs_static:
    assert property (!$rose(s_axi_bvalid) |-> $stable(ctl)) else $error("Output moved alone.");
    chk_mask_read:
    assert property (rd_take && s_axi_araddr == BASE_ADDR + 32'hC
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("Mask alias read.");
    chk_mask_write:
    assert property (wr_take && s_axi_awaddr == BASE_ADDR + 32'hC
        |=> ##1 s_axi_bresp == 2'b10 && $stable(ctl)) else $error("Mask alias written.");
    chk_reserved_zero:
    assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFF80_8080) == 32'h0)
        else $error("Reserved bits not zero.");
    chk_alias_read:
    assert property (rd_take && s_axi_araddr[31:4] == BASE_ADDR[31:4]
        && s_axi_araddr[3:0] inside {4'h0, 4'h4, 4'h8}
        |=> s_axi_rresp == 2'b00 && s_axi_rdata == $past(ctl))
        else $error("Alias read wrong.");
endmodule

bind rcr_top rcr_checker #(.BASE_ADDR(BASE_ADDR)) u_rcr_checker
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .digital_reg_source_sel, .digital_reg_bias_sel,
    .digital_reg_out_code, .memory_reg_source_sel, .memory_reg_bias_sel,
    .memory_reg_out_code, .analog_reg_source_sel, .analog_reg_bias_sel,
    .analog_reg_out_code
);

// >>> dv/regulator_control_regs_test.sv
// Self-checking bench for the regulator control bank over AXI4-Lite.
// Assumes rcr_top with its default base address and the bound checker.
`timescale 1ns/1ps

module regulator_control_regs_test;
    // ****************************************************************
    // Signals
    // ****************************************************************
    localparam logic [31:0] BASE = rcr_pkg::RCR_BASE_ADDR;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr  = 32'h0;
    logic [31:0] wdata   = 32'h0;
    logic [31:0] araddr  = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [31:0] exp_q;
    logic        ds, db, ms, mb, as, ab;
    logic [4:0]  dc, mc, ac;
    int          bad_count = 0;
    int          checked   = 0;
    int          cycles    = 0;
    int          seed      = 83443;
    int          bits[6]   = '{22, 21, 14, 13, 6, 5};

    // Free-running 125 MHz clock.
    always #4 aclk = ~aclk;

    // Outputs regrouped in register layout for one comparison per write.
    wire logic [31:0] outs = {9'h0, ds, db, dc, 1'b0, ms, mb, mc, 1'b0, as, ab, ac};

    rcr_top DUT
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .digital_reg_source_sel(ds),
        .digital_reg_bias_sel(db), .digital_reg_out_code(dc), .memory_reg_source_sel(ms),
        .memory_reg_bias_sel(mb), .memory_reg_out_code(mc), .analog_reg_source_sel(as),
        .analog_reg_bias_sel(ab), .analog_reg_out_code(ac)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Expected word: strobed lanes replaced, ORed or cleared by alias kind.
    function automatic logic [31:0] nxt(input logic [31:0] cur, input logic [31:0] d,
                                        input logic [3:0] s, input int k);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        case (k)
            0: cur = (cur & ~m) | (d & m);
            1: cur = cur | (d & m);
            default: cur = cur & ~(d & m);
        endcase
        return cur & 32'h007F_7F7F;
    endfunction

    // Write with a random stall on the response; called just after an edge.
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge aclk);
            pa = pa && !ta;
            pw = pw && !tw;
            awvalid <= pa;
            wvalid <= pw;
        end
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        bready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (!ta);
        bready <= 1'b0;
    endtask

    // Read one word and compare data and response.
    task automatic rdc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic t;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            t = arready;
            @(posedge aclk);
        end while (!t);
        arvalid <= 1'b0;
        repeat ($unsigned($random(seed)) % 3) @(posedge aclk);
        rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            t = rvalid;
            chk(t ? rdata : ed, ed);
            chk(t ? 32'(rresp) : 32'(er), 32'(er));
            @(posedge aclk);
        end while (!t);
        rready <= 1'b0;
    endtask

    // Write through alias k, then compare response and outputs.
    task automatic acc(input int k, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        wr(BASE + 32'(4 * k), d, s, r);
        exp_q = nxt(exp_q, d, s, k);
        chk(32'(r), 32'h0);
        @(negedge aclk);
        chk(outs, exp_q);
        @(posedge aclk);
    endtask

    // Watchdog: a hang counts as a mismatch.
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test;
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [1:0] r;
        int k;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        exp_q = 32'h0034_3434;
        for (k = 0; k < 3; k++)
            rdc(BASE + 32'(4 * k), exp_q, 2'b00);
        acc(0, 32'h007F_7F7F, 4'hF);
        acc(0, 32'h0, 4'hF);
        // each select bit set then cleared
        foreach (bits[i])
        begin
            acc(1, 32'h1 << bits[i], 4'hF);
            acc(2, 32'h1 << bits[i], 4'hF);
        end
        acc(0, 32'h0010_1010, 4'hF);
        acc(0, 32'h001F_1F1F, 4'hF);
        acc(0, 32'h0000_0505, 4'h2);
        // mask alias and unmapped place refused
        wr(BASE + 32'hC, 32'h007F_7F7F, 4'hF, r);
        chk(32'(r), 32'h2);
        wr(BASE + 32'h10, 32'h0, 4'hF, r);
        chk(32'(r), 32'h2);
        rdc(BASE + 32'hC, 32'h0, 2'b10);
        rdc(BASE + 32'h4, exp_q, 2'b00);
        // random alias writes: set and clear keep memory and analog codes, plain zeroes them in strobed lanes
        repeat (60)
        begin
            k = $unsigned($random(seed)) % 3;
            acc(k, $random(seed) & 32'h007F_6060, 4'($random(seed)));
            rdc(BASE + 32'(4 * ($unsigned($random(seed)) % 3)), exp_q, 2'b00);
        end
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(outs, 32'h0034_3434);
        @(posedge aclk);
        stop_test;
    end
endmodule
